/* core_timer_consts.vh */
// constants for the core timer, periodic tick and watchdog block
`ifndef CORE_TIMER_CONSTS_VH
`define CORE_TIMER_CONSTS_VH

// register indexes; byte address is four times the index
`define CT_IDX_CTRL 13'h0008
`define CT_IDX_COUNT 13'h0009
`define CT_IDX_SERVICE 13'h1FF0

// control/status field positions
`define CT_BIT_OVF_FLAG 7
`define CT_BIT_TICK_FLAG 6
`define CT_BIT_OVF_IE 5
`define CT_BIT_TICK_IE 4
`define CT_BIT_OVF_ACK 3
`define CT_BIT_TICK_ACK 2
`define CT_BIT_RATE_HI 1
`define CT_BIT_RATE_LO 0
`define CT_BIT_SERVICE 0

// reset value of the rate select field
`define CT_RATE_RESET 2'h3

// core tick source divided by four feeds the chain
`define CT_PRESC_LAST 2'h3

// chain bit whose wrap gives the fastest-select tick (divide 2^14)
`define CT_TICK_BASE 11

// start-up delays in cycles
`define CT_STARTUP_SHORT 12'h0E0
`define CT_STARTUP_LONG 12'hFE0

// watchdog counts eight tick periods
`define CT_WDG_LAST 3'h7

`endif

/* core_timer_periodic_watchdog.v */
// core timer: 15-stage chain, overflow flag, periodic tick and watchdog
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "core_timer_consts.vh"

module core_timer_periodic_watchdog #(
   parameter WATCHDOG_EN = 1,
   parameter ADDR_W = 15
) (
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire [ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire long_startup_i,
   input wire halt_i,
   output reg irq_o,
   output reg device_reset_o,
   output reg watchdog_reset_o,
   output reg wake_hold_o
);

   // sequencing states
   // start: device held in reset while the start-up delay runs
   // run: normal counting, flags and watchdog active
   // halt: oscillator stopped, chain and watchdog frozen
   // wake: stabilisation delay after halt, chain still frozen
   localparam [1:0] S_START = 2'h0;
   localparam [1:0] S_RUN = 2'h1;
   localparam [1:0] S_HALT = 2'h2;
   localparam [1:0] S_WAKE = 2'h3;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [11:0] dly_q;
   reg [11:0] dly_d;
   reg [1:0] presc_q;
   reg [14:0] chain_q;
   reg [14:0] chain_d;
   reg [2:0] wdg_q;
   reg [2:0] wdg_d;
   reg ovf_flag_q;
   reg tick_flag_q;
   reg ovf_ie_q;
   reg tick_ie_q;
   reg [1:0] rate_q;
   reg [31:0] rdata_d;

   wire [12:0] word_idx;
   wire counting;
   wire advance;
   wire ovf_evt;
   wire tick_evt;
   wire wdg_timeout;
   wire acc_wr;
   wire acc_rd;
   wire wr_ctrl;
   wire wr_service;
   wire [11:0] dly_last;
   wire [3:0] tick_cand;

   // word index of the byte address; low two bits ignored
   // the register map is word aligned, so a byte access inside a word
   // reaches the same register as a full word access
   assign word_idx = avs_address_i[ADDR_W-1:2];

   // a request completes at the edge where waitrequest is seen low
   // side effects happen only at that edge, so a request that is held
   // across several wait cycles acts exactly once
   assign acc_wr = avs_write_i && !avs_waitrequest_o;
   assign acc_rd = avs_read_i && !avs_waitrequest_o;

   // only the low byte lane carries the eight-bit registers
   assign wr_ctrl = acc_wr && avs_byteenable_i[0] &&
                    (word_idx == `CT_IDX_CTRL);
   assign wr_service = acc_wr && avs_byteenable_i[0] &&
                       (word_idx == `CT_IDX_SERVICE);

   // static delay pick
   // the pick is read live; changing it mid-delay is not supported,
   // it is meant to be tied off at build time
   assign dly_last = long_startup_i ? (`CT_STARTUP_LONG - 12'h001) :
                     (`CT_STARTUP_SHORT - 12'h001);

   // chain runs in reset hold and normal run; halt stops the oscillator
   // counting in the reset hold is harmless, the chain is cleared again
   // at the edge where the hold ends
   assign counting = (state_q == S_START) || (state_q == S_RUN);

   // divide by four
   // one synchronous enable replaces the ripple stages of the original
   // chain, so every stage changes on the same clock edge
   assign advance = counting && (presc_q == `CT_PRESC_LAST);

   // wrap of the low counter
   // flags only count in run, so the hold before release sets nothing
   assign ovf_evt = advance && (chain_q[7:0] == 8'hFF) &&
                    (state_q == S_RUN);

   // tick candidates from the top four stages
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_tick
         // stage wraps once per 2^(14+gi) bus cycles
         assign tick_cand[gi] =
            &chain_q[`CT_TICK_BASE+gi:0];
      end
   endgenerate

   assign tick_evt = advance && tick_cand[rate_q] &&
                     (state_q == S_RUN);

   // eighth tick times out when fitted
   // a service write in the same cycle as the eighth tick does not
   // save the device; software must service with margin
   assign wdg_timeout = (WATCHDOG_EN != 0) && tick_evt &&
                        (wdg_q == `CT_WDG_LAST);

   // sequencing and delay counter
   // one delay counter serves both the start-up hold and the wake hold,
   // since the two never overlap
   always @* begin
      state_d = state_q;
      dly_d = dly_q;
      case (state_q)
         S_START: begin
            // hold device in reset for the start-up delay
            if (dly_q == dly_last) begin
               state_d = S_RUN;
               dly_d = 12'h000;
            end else begin
               dly_d = dly_q + 12'h001;
            end
         end
         S_RUN: begin
            if (wdg_timeout) begin
               state_d = S_START;
               dly_d = 12'h000;
            end else if (halt_i) begin
               state_d = S_HALT;
            end
         end
         S_HALT: begin
            if (!halt_i) begin
               state_d = S_WAKE;
               dly_d = 12'h000;
            end
         end
         S_WAKE: begin
            if (dly_q == dly_last) begin
               state_d = S_RUN;
               dly_d = 12'h000;
            end else begin
               dly_d = dly_q + 12'h001;
            end
         end
         default: begin
            state_d = S_START;
            dly_d = 12'h000;
         end
      endcase
   end

   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= S_START;
         dly_q <= 12'h000;
      end else begin
         state_q <= state_d;
         dly_q <= dly_d;
      end
   end

   // prescaler; frozen with the chain so halt exit resumes cleanly
   // cleared at release so the first count lands four cycles later
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         presc_q <= 2'h0;
      end else if (state_q == S_START && state_d == S_RUN) begin
         presc_q <= 2'h0;
      end else if (counting) begin
         presc_q <= presc_q + 2'h1;
      end
   end

   // next chain value
   // clears take priority over the advance, so a restart always
   // begins from zero whatever the prescaler phase
   always @* begin
      chain_d = chain_q;
      // clear again when start-up delay releases
      if (state_q == S_START && state_d == S_RUN) begin
         chain_d = 15'h0000;
      end else if (wdg_timeout) begin
         chain_d = 15'h0000;
      end else if (advance) begin
         chain_d = chain_q + 15'h0001;
      end
   end

   // external reset clears the whole chain
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chain_q <= 15'h0000;
      end else begin
         chain_q <= chain_d;
      end
   end

   // watchdog divide-by-eight stage
   // the service write clears only this stage; the rest of the chain keeps
   // its phase, so the first tick after service may come early
   always @* begin
      wdg_d = wdg_q;
      if (WATCHDOG_EN == 0) begin
         wdg_d = 3'h0;
      end else if (state_q == S_START) begin
         wdg_d = 3'h0;
      // service write clears only this stage
      end else if (wr_service && !avs_writedata_i[`CT_BIT_SERVICE]) begin
         wdg_d = 3'h0;
      end else if (tick_evt) begin
         wdg_d = wdg_q + 3'h1;
      end
   end

   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdg_q <= 3'h0;
      end else begin
         wdg_q <= wdg_d;
      end
   end

   // flags: a new event wins over an acknowledge in the same cycle
   // losing an event would hide a tick from software, while a stale
   // flag only costs one extra interrupt
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_flag_q <= 1'b0;
         tick_flag_q <= 1'b0;
      end else if (wdg_timeout || state_q == S_START) begin
         ovf_flag_q <= 1'b0;
         tick_flag_q <= 1'b0;
      end else begin
         if (ovf_evt) begin
            ovf_flag_q <= 1'b1;
         // outside timeout and reset hold, cleared only by the acknowledge strobe
         end else if (wr_ctrl && avs_writedata_i[`CT_BIT_OVF_ACK]) begin
            ovf_flag_q <= 1'b0;
         end
         if (tick_evt) begin
            tick_flag_q <= 1'b1;
         // outside timeout and reset hold, cleared only by the acknowledge strobe
         end else if (wr_ctrl && avs_writedata_i[`CT_BIT_TICK_ACK]) begin
            tick_flag_q <= 1'b0;
         end
      end
   end

   // software-owned control fields
   // writes during the reset hold are overridden, so software sees
   // reset values until the device leaves reset
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_ie_q <= 1'b0;
         tick_ie_q <= 1'b0;
         rate_q <= `CT_RATE_RESET;
      end else if (wdg_timeout || state_q == S_START) begin
         ovf_ie_q <= 1'b0;
         tick_ie_q <= 1'b0;
         rate_q <= `CT_RATE_RESET;
      end else if (wr_ctrl) begin
         ovf_ie_q <= avs_writedata_i[`CT_BIT_OVF_IE];
         tick_ie_q <= avs_writedata_i[`CT_BIT_TICK_IE];
         // rate select also sets watchdog period
         rate_q <= avs_writedata_i[`CT_BIT_RATE_HI:`CT_BIT_RATE_LO];
      end
   end

   // read mux; unmapped and write-only locations read zero
   // reads have no side effects, so any register may be polled freely
   always @* begin
      rdata_d = 32'h00000000;
      if (word_idx == `CT_IDX_CTRL) begin
         rdata_d[`CT_BIT_OVF_FLAG] = ovf_flag_q;
         rdata_d[`CT_BIT_TICK_FLAG] = tick_flag_q;
         rdata_d[`CT_BIT_OVF_IE] = ovf_ie_q;
         rdata_d[`CT_BIT_TICK_IE] = tick_ie_q;
         // strobe bits stay zero on read
         rdata_d[`CT_BIT_OVF_ACK] = 1'b0;
         rdata_d[`CT_BIT_TICK_ACK] = 1'b0;
         rdata_d[`CT_BIT_RATE_HI:`CT_BIT_RATE_LO] = rate_q;
      end else if (word_idx == `CT_IDX_COUNT) begin
         rdata_d[7:0] = chain_q[7:0];
      end
   end

   // bus slave: waitrequest drops for one cycle a cycle after the request
   // every access costs two cycles; the fixed latency keeps read data
   // registered so the output comes straight from a flip-flop
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end else if (acc_wr || acc_rd) begin
         avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         avs_waitrequest_o <= 1'b0;
         // data stands while waitrequest is low
         avs_readdata_o <= avs_read_i ? rdata_d : 32'h00000000;
      end
   end

   // registered outputs
   // irq_o and watchdog_reset_o are one cycle behind their sources; the
   // hold outputs are registered from the next state, so they match the state
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
         device_reset_o <= 1'b1;
         watchdog_reset_o <= 1'b0;
         wake_hold_o <= 1'b0;
      end else begin
         // level request, held until flags acknowledged
         // each flag gated by its enable
         irq_o <= (tick_flag_q && tick_ie_q) || (ovf_flag_q && ovf_ie_q);
         // device held in reset until start-up ends
         device_reset_o <= (state_d == S_START);
         // one-cycle pulse marks a watchdog reset
         watchdog_reset_o <= wdg_timeout;
         wake_hold_o <= (state_d == S_WAKE);
      end
   end

endmodule // core_timer_periodic_watchdog

/* core_timer_checker.sv */
// bus, start-up and halt-exit relations at the core timer ports
`timescale 1ns/1ns
module core_timer_checker #(
   parameter WATCHDOG_EN = 1,
   parameter ADDR_W = 15
) (
   input wire ref_clk_i,
   input wire arst_n_i,
   input wire [ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire long_startup_i,
   input wire halt_i,
   input wire irq_o,
   input wire device_reset_o,
   input wire watchdog_reset_o,
   input wire wake_hold_o
);
   reg [12:0] hold_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // run length of the start-up and wake holds, to check the delay figure
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) hold_q <= 13'h0000;
      else hold_q <= (device_reset_o || wake_hold_o) ? hold_q + 13'h0001 : 13'h0000;
   end
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered next cycle");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   read_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   startup_len_a: assert property ($fell(device_reset_o) |-> hold_q >= 13'd223 && hold_q <= 13'd225)
      else $error("start-up delay length wrong");
   wake_len_a: assert property ($fell(wake_hold_o) |-> hold_q >= 13'd223 && hold_q <= 13'd225)
      else $error("wake delay length wrong");
   startup_quiet_a: assert property (device_reset_o && $past(device_reset_o) |-> !irq_o)
      else $error("interrupt during start-up");
   watchdog_restart_a: assert property (watchdog_reset_o |-> ##[0:2] device_reset_o)
      else $error("watchdog timeout without restart");
   halt_freeze_a: assert property (halt_i && $past(halt_i, 2) && !device_reset_o && !wake_hold_o |-> !watchdog_reset_o)
      else $error("watchdog fired in halt");
   cover property ($fell(device_reset_o));
   cover property ($fell(wake_hold_o));
   cover property ($rose(irq_o));
endmodule // core_timer_checker

/* core_timer_periodic_watchdog_tb.sv */
// register-level bench for the core timer block
`timescale 1ns/1ns
module core_timer_periodic_watchdog_tb;
   reg ref_clk_i, arst_n_i, avs_read_i, avs_write_i, halt_i;
   reg [14:0] avs_address_i;
   reg [31:0] avs_writedata_i;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, irq_o, device_reset_o, watchdog_reset_o, wake_hold_o;
   integer failures = 0, total_checks = 0, cyc = 0, n, t1, t2;
   reg [7:0] d, c1;
   core_timer_periodic_watchdog dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .long_startup_i(1'b0), .halt_i(halt_i), .irq_o(irq_o),
      .device_reset_o(device_reset_o), .watchdog_reset_o(watchdog_reset_o), .wake_hold_o(wake_hold_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // cycle ceiling guards against a hang
   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         failures = failures + 1;
         stop_test;
      end
   end
   task stop_test;
      begin
         if (failures == 0 && total_checks > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // one access; held until waitrequest is seen low, released after that edge
   task acc(input wr, input [14:0] a, input [7:0] w);
      begin
         avs_address_i <= a;
         avs_writedata_i <= {24'h000000, w};
         if (wr) avs_write_i <= 1'b1;
         else avs_read_i <= 1'b1;
         // request stands until the rising edge that samples waitrequest low
         @(posedge ref_clk_i);
         while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
         d = avs_readdata_o[7:0];
         t2 = cyc;
         avs_read_i <= 1'b0;
         avs_write_i <= 1'b0;
         @(posedge ref_clk_i);
      end
   endtask
   task wait_for(input integer lim, input integer which);
      begin
         n = 0;
         while (((which == 0) ? device_reset_o : !irq_o) !== 1'b0 && n < lim) begin
            @(posedge ref_clk_i);
            n = n + 1;
         end
         chk({7'h00, n < lim}, 8'h01);
      end
   endtask
   task do_reset;
      begin
         arst_n_i <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
         arst_n_i <= 1'b1;
         @(posedge ref_clk_i);
      end
   endtask
   initial begin
      {arst_n_i, avs_read_i, avs_write_i, halt_i} = 4'h0;
      avs_address_i = 15'h0000;
      avs_writedata_i = 32'h00000000;
      do_reset;
      wait_for(300, 0);
      acc(0, 15'h0020, 8'h00); chk(d, 8'h03);
      acc(0, 15'h0040, 8'h00); chk(d, 8'h00);
      // count pace: 44 cycles between reads give 11 steps
      acc(0, 15'h0024, 8'h00); c1 = d; t1 = t2;
      repeat (41) @(posedge ref_clk_i);
      acc(0, 15'h0024, 8'h00); chk(d - c1, (t2 - t1) >> 2);
      // overflow flag and its interrupt
      acc(1, 15'h0020, 8'h2F);
      wait_for(1100, 1);
      acc(0, 15'h0020, 8'h00); chk(d, 8'hA3);
      acc(1, 15'h0020, 8'h63); acc(0, 15'h0020, 8'h00); chk(d, 8'hA3);
      acc(1, 15'h0020, 8'h2B); acc(0, 15'h0020, 8'h00); chk(d, 8'h23);
      chk({7'h00, irq_o}, 8'h00);
      // periodic tick at the fastest rate, overflow masked
      acc(1, 15'h0020, 8'h18);
      wait_for(17000, 1);
      acc(0, 15'h0020, 8'h00); chk(d & 8'h7F, 8'h50);
      acc(1, 15'h0020, 8'h14); acc(0, 15'h0020, 8'h00); chk(d & 8'h7F, 8'h10);
      chk({7'h00, irq_o}, 8'h00);
      acc(1, 15'h7FC0, 8'h00);
      // halt freezes the chain, exit holds for the start-up delay
      halt_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      acc(0, 15'h0024, 8'h00); c1 = d;
      repeat (50) @(posedge ref_clk_i);
      acc(0, 15'h0024, 8'h00); chk(d, c1);
      halt_i <= 1'b0;
      n = 0;
      t1 = 0;
      while ((n == 0 || wake_hold_o) && t1 < 400) begin
         @(posedge ref_clk_i);
         t1 = t1 + 1;
         if (wake_hold_o === 1'b1) n = n + 1;
      end
      chk(n, 8'd224);
      // reset mid-run clears enables and chain, returns rate to its reset value
      do_reset;
      acc(0, 15'h0020, 8'h00); chk(d, 8'h03);
      wait_for(300, 0);
      acc(0, 15'h0024, 8'h00); chk(d & 8'hFC, 8'h00);
      stop_test;
   end
endmodule // core_timer_periodic_watchdog_tb
bind core_timer_periodic_watchdog core_timer_checker #(.WATCHDOG_EN(WATCHDOG_EN), .ADDR_W(ADDR_W)) chk_u (
   .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .long_startup_i(long_startup_i),
   .halt_i(halt_i), .irq_o(irq_o), .device_reset_o(device_reset_o), .watchdog_reset_o(watchdog_reset_o),
   .wake_hold_o(wake_hold_o));
